//--- src/ccp_clock_power.sv
// Codec identification, digital power and system clock control registers
// Overview of operation
// - Boost enable bit 0: one switches boost on, zero switches it off.
// - Auto volume enable bit 0 switches it on or off, no ramp needed.
// - Identification bits 15:8 hold a fixed read-only part code; writes ignored.
// - Identification bits 7:0 hold read-only revision, reading 0x00.
// - Power bit 6 enables the ADC block; resets to zero.
// - Power bit 5 enables the DAC block; resets to zero.
// - Power bit 4 enables the audio processor; resets to zero.
// - Power bit 1 enables serial audio output; resets to zero.
// - Power bit 0 enables serial audio input; resets to zero.
// - Rate divider bits 5:4 give full, half, quarter, sixth rate; resets 0.
// - Clock ratio always refers to the base rate, not the divided rate.
// - Base rate bits 3:2 select 32, 44.1, 48, 96 kHz; resets to 2.
// - Ratio bits 1:0 give 256, 384, 512 times Fs, or PLL; resets 0.
//
// The implementer's own choice: strobed register access.
module ccp_clock_power
	import ccp_pkg::*;
#(
	parameter logic [7:0] PART_ID = 8'h5C, // Arbitrary value
	parameter int CLK_HZ = 125000000
) (
	input wire logic core_clk, // Core clock, 125 MHz
	input wire logic rst, // Async reset, active high
	input wire ccp_pkg::ccp_bus_req_t busReq, // Register request
	output logic [15:0] rdata, // Read data, cycle after read
	output ccp_pkg::ccp_power_t powerOn, // Block enables
	output ccp_pkg::ccp_clock_t clockCfg, // Clock settings
	output ccp_pkg::ccp_effect_t effectCfg, // Effect settings
	output logic pllSelected, // Master clock ratio selects PLL
	output logic [9:0] mclkMultiple, // Master clock over base rate
	output logic sampleTick // Pulse at the divided sample rate
);
	// ==================== State ====================
	typedef struct packed {
		ccp_power_t pwr;
		ccp_clock_t clk;
		ccp_effect_t eff;
		logic [15:0] rdata;
	} ccp_state_t;

	ccp_state_t st, next_st;
	logic [15:0] idWord, powerWord, clockWord, boostWord, autoWord, surrWord;
	logic [15:0] boostEnWord;

	always_comb begin
		idWord = {PART_ID, CCP_REV_VALUE};
		powerWord = 16'h0000;
		powerWord[CCP_ADC_BIT] = st.pwr.adcOn;
		powerWord[CCP_DAC_BIT] = st.pwr.dacOn;
		powerWord[CCP_PROC_BIT] = st.pwr.procOn;
		powerWord[CCP_SOUT_BIT] = st.pwr.serialOutOn;
		powerWord[CCP_SIN_BIT] = st.pwr.serialInOn;
		clockWord = 16'h0000;
		clockWord[CCP_DIV_LSB +: 2] = st.clk.rateDivider;
		clockWord[CCP_FS_LSB +: 2] = st.clk.baseSampleRate;
		clockWord[CCP_RATIO_LSB +: 2] = st.clk.masterClockRatio;
		boostWord = 16'h0000;
		boostWord[CCP_LEVEL_LSB +: 7] = st.eff.boostLevel;
		boostEnWord = 16'h0000;
		boostEnWord[CCP_EN_BIT] = st.eff.boostOn;
		autoWord = 16'h0000;
		autoWord[CCP_EN_BIT] = st.eff.autoVolumeOn;
		surrWord = 16'h0000;
		surrWord[CCP_WIDTH_LSB +: 3] = st.eff.surroundWidth;
		surrWord[CCP_EN_BIT +: 2] = st.eff.surroundSelect;
	end

	// ==================== Register access ====================
	always_comb begin
		next_st = st;
		next_st.rdata = 16'h0000;
		if (busReq.wr) begin
			unique case (busReq.addr)
				CCP_OFS_POWER: begin
					next_st.pwr.adcOn = busReq.wdata[CCP_ADC_BIT];
					next_st.pwr.dacOn = busReq.wdata[CCP_DAC_BIT];
					next_st.pwr.procOn = busReq.wdata[CCP_PROC_BIT];
					next_st.pwr.serialOutOn = busReq.wdata[CCP_SOUT_BIT];
					next_st.pwr.serialInOn = busReq.wdata[CCP_SIN_BIT];
				end
				CCP_OFS_CLOCK: begin
					next_st.clk.rateDivider = busReq.wdata[CCP_DIV_LSB +: 2];
					next_st.clk.baseSampleRate = busReq.wdata[CCP_FS_LSB +: 2];
					next_st.clk.masterClockRatio = busReq.wdata[CCP_RATIO_LSB +: 2];
				end
				CCP_OFS_BOOST: begin
					next_st.eff.boostLevel = busReq.wdata[CCP_LEVEL_LSB +: 7];
				end
				CCP_OFS_BOOST_EN: begin
					next_st.eff.boostOn = busReq.wdata[CCP_EN_BIT];
				end
				CCP_OFS_AUTOVOL: begin
					next_st.eff.autoVolumeOn = busReq.wdata[CCP_EN_BIT];
				end
				CCP_OFS_SURROUND: begin
					next_st.eff.surroundWidth = busReq.wdata[CCP_WIDTH_LSB +: 3];
					next_st.eff.surroundSelect = busReq.wdata[CCP_EN_BIT +: 2];
				end
				default: begin
				end
			endcase
		end
		if (busReq.rd) begin
			unique case (busReq.addr)
				CCP_OFS_ID: next_st.rdata = idWord;
				CCP_OFS_POWER: next_st.rdata = powerWord;
				CCP_OFS_CLOCK: next_st.rdata = clockWord;
				CCP_OFS_BOOST: next_st.rdata = boostWord;
				CCP_OFS_BOOST_EN: next_st.rdata = boostEnWord;
				CCP_OFS_AUTOVOL: next_st.rdata = autoWord;
				CCP_OFS_SURROUND: next_st.rdata = surrWord;
				default: next_st.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
			st.clk.baseSampleRate <= CCP_FS_RESET;
			st.eff.boostLevel <= CCP_LEVEL_RESET;
			st.eff.surroundWidth <= CCP_WIDTH_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ==================== Outputs ====================
	assign rdata = st.rdata;
	assign powerOn = st.pwr;
	assign clockCfg = st.clk;
	assign effectCfg = st.eff;
	assign pllSelected = (st.clk.masterClockRatio == CCP_RATIO_PLL);

	// Ratio is against base rate, divider not applied
	always_comb begin
		unique case (st.clk.masterClockRatio)
			2'h0: mclkMultiple = 10'd256;
			2'h1: mclkMultiple = 10'd384;
			2'h2: mclkMultiple = 10'd512;
			default: mclkMultiple = 10'd0;
		endcase
	end

	// Sample timing only runs while a converter, the audio processor or a serial path is on
	ccp_rate_gen #(
		.CLK_HZ(CLK_HZ)
	) u_rate (
		.core_clk(core_clk),
		.rst(rst),
		.enable(|st.pwr),
		.baseRate(ccp_fs_t'(st.clk.baseSampleRate)),
		.rateDivider(ccp_div_t'(st.clk.rateDivider)),
		.sampleTick(sampleTick)
	);

	// ==================== Assertions ====================
	sequence powerWrite;
		busReq.wr && busReq.addr == CCP_OFS_POWER;
	endsequence

	sequence idRead;
		busReq.rd && busReq.addr == CCP_OFS_ID;
	endsequence

	property idStable;
		@(posedge core_clk) disable iff (rst)
		idRead |=> rdata == {PART_ID, CCP_REV_VALUE};
	endproperty

	id_read_fixed_a: assert property (idStable)
		else $error("identification read wrong");

	rev_zero_a: assert property (@(posedge core_clk) disable iff (rst)
		idRead |=> rdata[7:0] == 8'h00)
		else $error("revision not zero");

	adc_enable_a: assert property (@(posedge core_clk) disable iff (rst)
		powerWrite |=> powerOn.adcOn == $past(busReq.wdata[CCP_ADC_BIT]))
		else $error("adc enable not taken");

	dac_enable_a: assert property (@(posedge core_clk) disable iff (rst)
		powerWrite |=> powerOn.dacOn == $past(busReq.wdata[CCP_DAC_BIT]))
		else $error("dac enable not taken");

	proc_enable_a: assert property (@(posedge core_clk) disable iff (rst)
		powerWrite |=> powerOn.procOn == $past(busReq.wdata[CCP_PROC_BIT]))
		else $error("processor enable not taken");

	sout_enable_a: assert property (@(posedge core_clk) disable iff (rst)
		powerWrite |=> powerOn.serialOutOn == $past(busReq.wdata[CCP_SOUT_BIT]))
		else $error("serial out enable not taken");

	sin_enable_a: assert property (@(posedge core_clk) disable iff (rst)
		powerWrite |=> powerOn.serialInOn == $past(busReq.wdata[CCP_SIN_BIT]))
		else $error("serial in enable not taken");

	power_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		!(busReq.wr && busReq.addr == CCP_OFS_POWER) |=> $stable(powerOn))
		else $error("power changed without write");

	reserved_zero_a: assert property (@(posedge core_clk) disable iff (rst)
		$past(busReq.rd) && $past(busReq.addr) == CCP_OFS_CLOCK
		|-> (rdata & ~CCP_CLOCK_MASK) == 16'h0000)
		else $error("reserved clock bits set");

	ratio_pll_a: assert property (@(posedge core_clk) disable iff (rst)
		pllSelected |-> mclkMultiple == 10'd0 && clockCfg.masterClockRatio == 2'h3)
		else $error("pll decode wrong");

	boost_enable_a: assert property (@(posedge core_clk) disable iff (rst)
		busReq.wr && busReq.addr == CCP_OFS_BOOST_EN
		|=> effectCfg.boostOn == $past(busReq.wdata[0]))
		else $error("boost enable not taken");

	autovol_enable_a: assert property (@(posedge core_clk) disable iff (rst)
		busReq.wr && busReq.addr == CCP_OFS_AUTOVOL
		|=> effectCfg.autoVolumeOn == $past(busReq.wdata[0]))
		else $error("auto volume enable not taken");

	clock_write_a: assert property (@(posedge core_clk) disable iff (rst)
		busReq.wr && busReq.addr == CCP_OFS_CLOCK
		|=> clockCfg.rateDivider == $past(busReq.wdata[5:4])
			&& clockCfg.baseSampleRate == $past(busReq.wdata[3:2]))
		else $error("clock fields not taken");

	sequence boostLevelWrite;
		busReq.wr && busReq.addr == CCP_OFS_BOOST;
	endsequence

	sequence surroundWrite;
		busReq.wr && busReq.addr == CCP_OFS_SURROUND;
	endsequence

	sequence clockWrite;
		busReq.wr && busReq.addr == CCP_OFS_CLOCK;
	endsequence

	boost_level_a: assert property (@(posedge core_clk) disable iff (rst)
		boostLevelWrite |=> effectCfg.boostLevel == $past(busReq.wdata[CCP_LEVEL_LSB +: 7]))
		else $error("boost level not taken");

	boost_reserved_a: assert property (@(posedge core_clk) disable iff (rst)
		$past(busReq.rd) && $past(busReq.addr) == CCP_OFS_BOOST
		|-> (rdata & ~CCP_BOOST_MASK) == 16'h0000)
		else $error("boost level read wrong");

	surround_width_a: assert property (@(posedge core_clk) disable iff (rst)
		surroundWrite |=> effectCfg.surroundWidth == $past(busReq.wdata[CCP_WIDTH_LSB +: 3]))
		else $error("surround width not taken");

	id_write_ignored_a: assert property (@(posedge core_clk) disable iff (rst)
		busReq.wr && busReq.addr == CCP_OFS_ID |=> $stable({powerOn, clockCfg, effectCfg}))
		else $error("identification write had effect");

	read_idle_a: assert property (@(posedge core_clk) disable iff (rst)
		!busReq.rd |=> rdata == 16'h0000)
		else $error("read data without read");

	power_reserved_a: assert property (@(posedge core_clk) disable iff (rst)
		$past(busReq.rd) && $past(busReq.addr) == CCP_OFS_POWER
		|-> (rdata & ~CCP_POWER_MASK) == 16'h0000)
		else $error("reserved power bits set");

	clock_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		!(busReq.wr && busReq.addr == CCP_OFS_CLOCK) |=> $stable(clockCfg))
		else $error("clock changed without write");

	ratio_write_a: assert property (@(posedge core_clk) disable iff (rst)
		clockWrite |=> clockCfg.masterClockRatio == $past(busReq.wdata[CCP_RATIO_LSB +: 2]))
		else $error("clock ratio not taken");

	ratio_base_a: assert property (@(posedge core_clk) disable iff (rst)
		clockCfg.masterClockRatio == 2'h0 |-> mclkMultiple == 10'd256)
		else $error("ratio 256 decode wrong");

	ratio_mid_a: assert property (@(posedge core_clk) disable iff (rst)
		clockCfg.masterClockRatio == 2'h1 |-> mclkMultiple == 10'd384)
		else $error("ratio 384 decode wrong");

	tick_off_a: assert property (@(posedge core_clk) disable iff (rst)
		powerOn == 5'h00 |=> !sampleTick)
		else $error("tick while powered down");

endmodule // ccp_clock_power

//--- src/ccp_pkg.sv
// Package: register map, field layout and reset values of the codec clock/power block
package ccp_pkg;

	// ==================== Register offsets ====================
	localparam int CCP_AW = 16;
	localparam logic [15:0] CCP_OFS_ID = 16'h0000;
	localparam logic [15:0] CCP_OFS_POWER = 16'h0002;
	localparam logic [15:0] CCP_OFS_CLOCK = 16'h0004;
	localparam logic [15:0] CCP_OFS_BOOST = 16'h0010;
	localparam logic [15:0] CCP_OFS_AUTOVOL = 16'h0012;
	localparam logic [15:0] CCP_OFS_SURROUND = 16'h0014;
	localparam logic [15:0] CCP_OFS_BOOST_EN = 16'h0016;

	// ==================== Field positions ====================
	localparam int CCP_PART_LSB = 8;
	localparam int CCP_REV_LSB = 0;
	localparam int CCP_ADC_BIT = 6;
	localparam int CCP_DAC_BIT = 5;
	localparam int CCP_PROC_BIT = 4;
	localparam int CCP_SOUT_BIT = 1;
	localparam int CCP_SIN_BIT = 0;
	localparam int CCP_DIV_LSB = 4;
	localparam int CCP_FS_LSB = 2;
	localparam int CCP_RATIO_LSB = 0;
	localparam int CCP_EN_BIT = 0;
	localparam int CCP_LEVEL_LSB = 0;
	localparam int CCP_WIDTH_LSB = 4;

	// ==================== Masks and reset values ====================
	localparam logic [15:0] CCP_POWER_MASK = 16'h0073;
	localparam logic [15:0] CCP_CLOCK_MASK = 16'h003F;
	localparam logic [15:0] CCP_BOOST_MASK = 16'h007F;
	localparam logic [1:0] CCP_FS_RESET = 2'h2;
	localparam logic [1:0] CCP_RATIO_PLL = 2'h3;
	localparam logic [6:0] CCP_LEVEL_RESET = 7'h1F;
	localparam logic [6:0] CCP_LEVEL_LOWEST = 7'h7F;
	localparam logic [2:0] CCP_WIDTH_RESET = 3'h4;
	localparam logic [7:0] CCP_REV_VALUE = 8'h00;

	// ==================== Encodings ====================
	typedef enum logic [1:0] {
		CCP_DIV_1 = 2'h0,
		CCP_DIV_2 = 2'h1,
		CCP_DIV_4 = 2'h2,
		CCP_DIV_6 = 2'h3
	} ccp_div_t;

	typedef enum logic [1:0] {
		CCP_FS_32K = 2'h0,
		CCP_FS_44K1 = 2'h1,
		CCP_FS_48K = 2'h2,
		CCP_FS_96K = 2'h3
	} ccp_fs_t;

	// ==================== Carriers ====================
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} ccp_bus_req_t;

	typedef struct packed {
		logic adcOn;
		logic dacOn;
		logic procOn;
		logic serialOutOn;
		logic serialInOn;
	} ccp_power_t;

	typedef struct packed {
		logic [1:0] rateDivider;
		logic [1:0] baseSampleRate;
		logic [1:0] masterClockRatio;
	} ccp_clock_t;

	typedef struct packed {
		logic boostOn;
		logic [6:0] boostLevel;
		logic autoVolumeOn;
		logic [2:0] surroundWidth;
		logic [1:0] surroundSelect;
	} ccp_effect_t;

endpackage

//--- src/ccp_rate_gen.sv
// Sample-rate enable pulse divider from the core clock
module ccp_rate_gen
	import ccp_pkg::*;
#(
	parameter int CLK_HZ = 125000000
) (
	input wire logic core_clk, // Core clock
	input wire logic rst, // Async reset, active high
	input wire logic enable, // Run the divider
	input wire ccp_pkg::ccp_fs_t baseRate, // Base sample rate
	input wire ccp_pkg::ccp_div_t rateDivider, // Rate divider code
	output logic sampleTick // One-cycle pulse at the divided rate
);
	localparam int CW = 24;
	localparam logic [CW-1:0] P32 = CW'(CLK_HZ / 32000);
	localparam logic [CW-1:0] P441 = CW'(CLK_HZ / 44100);
	localparam logic [CW-1:0] P48 = CW'(CLK_HZ / 48000);
	localparam logic [CW-1:0] P96 = CW'(CLK_HZ / 96000);

	if (CLK_HZ / 32000 * 6 >= (1 << CW) || CLK_HZ < 96000) begin : g_bad_clk
		$error("ccp_rate_gen: CLK_HZ out of range");
	end

	typedef struct packed {
		logic [CW-1:0] count;
		logic [2:0] sub;
		logic tick;
	} ccp_gen_state_t;

	ccp_gen_state_t st, next_st;
	logic [CW-1:0] basePeriod;
	logic [2:0] subLimit;

	always_comb begin
		unique case (baseRate)
			CCP_FS_32K: basePeriod = P32;
			CCP_FS_44K1: basePeriod = P441;
			CCP_FS_48K: basePeriod = P48;
			CCP_FS_96K: basePeriod = P96;
		endcase
		unique case (rateDivider)
			CCP_DIV_1: subLimit = 3'd0;
			CCP_DIV_2: subLimit = 3'd1;
			CCP_DIV_4: subLimit = 3'd3;
			CCP_DIV_6: subLimit = 3'd5;
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (!enable) begin
			next_st.count = '0;
			next_st.sub = '0;
		end else if (st.count >= basePeriod - CW'(1)) begin
			next_st.count = '0;
			if (st.sub >= subLimit) begin
				next_st.sub = '0;
				next_st.tick = 1'b1;
			end else begin
				next_st.sub = st.sub + 3'd1;
			end
		end else begin
			next_st.count = st.count + CW'(1);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign sampleTick = st.tick;

endmodule // ccp_rate_gen

//--- test/ccp_clock_power_tb.sv
// Self-checking testbench for the codec clock, power and identification registers
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import ccp_pkg::*;

	// ==================== Signals ====================
	localparam logic [7:0] TB_PART = 8'h3B; // Arbitrary value
	localparam int TB_CLK_HZ = 960000;
	logic coreClk;
	logic rst;
	ccp_pkg::ccp_bus_req_t busReq;
	logic [15:0] rdata;
	ccp_pkg::ccp_power_t powerOn;
	ccp_pkg::ccp_clock_t clockCfg;
	ccp_pkg::ccp_effect_t effectCfg;
	logic pllSelected;
	logic [9:0] mclkMultiple;
	logic sampleTick;
	int nErrors = 0;
	int samplesChecked = 0;
	int cycles = 0;

	ccp_clock_power #(.PART_ID(TB_PART), .CLK_HZ(TB_CLK_HZ)) dut (
		.core_clk(coreClk),
		.rst(rst),
		.busReq(busReq),
		.rdata(rdata),
		.powerOn(powerOn),
		.clockCfg(clockCfg),
		.effectCfg(effectCfg),
		.pllSelected(pllSelected),
		.mclkMultiple(mclkMultiple),
		.sampleTick(sampleTick)
	);

	// ==================== Clock, timeout ====================
	initial begin
		coreClk = 1'b0;
		forever #4 coreClk = ~coreClk;
	end

	always @(posedge coreClk) begin
		cycles++;
		if (cycles == 20000) begin
			nErrors++;
			$display("[FAIL] timeout expected 0 seen %0d", cycles);
			results();
		end
	end

	// ==================== Bus and compare tasks ====================
	task automatic busWrite(input logic [15:0] addr, input logic [15:0] data);
		@(posedge coreClk);
		busReq <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
		@(posedge coreClk);
		busReq.wr <= 1'b0;
		#1;
	endtask

	task automatic busRead(input logic [15:0] addr, output logic [15:0] data);
		@(posedge coreClk);
		busReq <= '{addr: addr, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge coreClk);
		busReq.rd <= 1'b0;
		#1;
		data = rdata;
	endtask

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		samplesChecked++;
		if (got !== exp) begin
			nErrors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic checkReg(input logic [15:0] addr, input logic [15:0] exp);
		logic [15:0] d;
		busRead(addr, d);
		check($sformatf("reg %h", addr), exp, d);
	endtask

	// ==================== Scenarios ====================
	task automatic testReset();
		check("powerOn", 16'h0000, {11'h000, powerOn});
		check("clockCfg", 16'h0008, {10'h000, clockCfg});
		check("boostLevel", 16'h001F, {9'h000, effectCfg.boostLevel});
		check("surroundWidth", 16'h0004, {13'h0000, effectCfg.surroundWidth});
		checkReg(CCP_OFS_ID, {TB_PART, 8'h00});
		checkReg(CCP_OFS_POWER, 16'h0000);
		checkReg(CCP_OFS_CLOCK, 16'h0008);
		repeat (60) @(posedge coreClk);
		#1;
		check("tick off", 16'h0000, {15'h0000, sampleTick});
		$display("test reset done");
	endtask

	task automatic testIdent();
		busWrite(CCP_OFS_ID, 16'hFFFF);
		checkReg(CCP_OFS_ID, {TB_PART, 8'h00});
		busWrite(16'h0006, 16'hFFFF);
		checkReg(16'h0006, 16'h0000);
		$display("test ident done");
	endtask

	task automatic testPower();
		busWrite(CCP_OFS_POWER, 16'hFFFF);
		check("powerOn all", 16'h001F, {11'h000, powerOn});
		checkReg(CCP_OFS_POWER, 16'h0073);
		busWrite(CCP_OFS_POWER, 16'h0041);
		check("adc sin", 16'h0011, {11'h000, powerOn});
		busWrite(CCP_OFS_POWER, 16'h0032);
		check("dac proc sout", 16'h000E, {11'h000, powerOn});
		checkReg(CCP_OFS_POWER, 16'h0032);
		$display("test power done");
	endtask

	task automatic testClock();
		logic [9:0] mult [4] = '{10'd256, 10'd384, 10'd512, 10'd0};
		for (int i = 0; i < 4; i++) begin
			busWrite(CCP_OFS_CLOCK, 16'hFFC0 | 16'(i * 21));
			check("clockCfg", 16'(i * 21), {10'h000, clockCfg});
			check("mclk", {6'h00, mult[i]}, {6'h00, mclkMultiple});
			check("pll", 16'(i == 3), {15'h0000, pllSelected});
			checkReg(CCP_OFS_CLOCK, 16'(i * 21));
		end
		$display("test clock done");
	endtask

	task automatic testTick();
		int n;
		busWrite(CCP_OFS_CLOCK, 16'h0018);
		check("mclk div", 16'd256, {6'h00, mclkMultiple});
		n = 0;
		while (sampleTick !== 1'b1 && n < 200) begin
			@(posedge coreClk);
			#1;
			n++;
		end
		n = 0;
		do begin
			@(posedge coreClk);
			#1;
			n++;
		end while (sampleTick !== 1'b1 && n < 200);
		check("tick period", 16'(2 * (TB_CLK_HZ / 48000)), 16'(n));
		$display("test tick done");
	endtask

	task automatic testEffects();
		busWrite(CCP_OFS_BOOST_EN, 16'h0001);
		check("boost on", 16'h0001, {15'h0000, effectCfg.boostOn});
		busWrite(CCP_OFS_BOOST_EN, 16'h0000);
		check("boost off", 16'h0000, {15'h0000, effectCfg.boostOn});
		busWrite(CCP_OFS_AUTOVOL, 16'h0001);
		check("avol on", 16'h0001, {15'h0000, effectCfg.autoVolumeOn});
		busWrite(CCP_OFS_AUTOVOL, 16'h0000);
		check("avol off", 16'h0000, {15'h0000, effectCfg.autoVolumeOn});
		$display("test effects done");
	endtask

	task automatic testRamps();
		int w;
		int lv;
		checkReg(CCP_OFS_SURROUND, 16'h0040);
		for (w = 5; w <= 7; w++) begin
			busWrite(CCP_OFS_SURROUND, 16'(w << CCP_WIDTH_LSB));
		end
		busWrite(CCP_OFS_SURROUND, 16'h0073);
		check("surround sel", 16'h0003, {14'h0000, effectCfg.surroundSelect});
		for (w = 6; w >= 4; w--) begin
			busWrite(CCP_OFS_SURROUND, 16'(w << CCP_WIDTH_LSB) | 16'h0003);
			check("surround step", 16'(w), {13'h0000, effectCfg.surroundWidth});
		end
		checkReg(CCP_OFS_SURROUND, 16'h0043);
		checkReg(CCP_OFS_BOOST, 16'h001F);
		for (lv = 16'h0020; lv <= 16'h007F; lv++) begin
			busWrite(CCP_OFS_BOOST, 16'(lv));
		end
		check("boost lowest", 16'h007F, {9'h000, effectCfg.boostLevel});
		busWrite(CCP_OFS_BOOST_EN, 16'h0001);
		check("boost en", 16'h0001, {15'h0000, effectCfg.boostOn});
		for (lv = 16'h007E; lv >= 16'h001F; lv--) begin
			busWrite(CCP_OFS_BOOST, 16'(lv));
		end
		checkReg(CCP_OFS_BOOST, 16'h001F);
		checkReg(CCP_OFS_BOOST_EN, 16'h0001);
		busWrite(CCP_OFS_CLOCK, {14'h0000, CCP_RATIO_PLL});
		check("pll sel", 16'h0001, {15'h0000, pllSelected});
		$display("test ramps done");
	endtask

	// ==================== Closing ====================
	task automatic results();
		$display("checks %0d mismatches %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		busReq = '0;
		repeat (6) @(posedge coreClk);
		rst <= 1'b0;
		@(posedge coreClk);
		#1;
		testReset();
		testIdent();
		testPower();
		testClock();
		testTick();
		testEffects();
		testRamps();
		results();
	end

endmodule // testbench
